// file: bench/dram_ctrl_model.sv
// stand-in for the dram controller: raises a refresh request on command
// assumes forced refresh in mode zero, which clears the pending request
`timescale 1ns/1ps
module dram_ctrl_model (
  input wire logic core_clk_in,
  input wire logic go_in,
  input wire logic force_refresh_cmd_n_in,
  output logic refresh_request_n_out
);
  logic armed;
  initial begin
    armed = 1'b0;
    refresh_request_n_out = 1'b1;
  end
  always @(posedge core_clk_in) begin
    armed <= go_in;
  end
  // pin moves off the sampling edge; it is asynchronous to the arbiter anyway
  always @(negedge core_clk_in) begin
    if (armed) begin
      refresh_request_n_out <= 1'b0;
    end else if (force_refresh_cmd_n_in === 1'b0) begin
      refresh_request_n_out <= 1'b1; // forced refresh clears it
    end
  end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the dram access and refresh arbiter
// assumes the dram controller stand-in; the host bus is driven here
`timescale 1ns/1ps
`define check(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %0h got %0h", nm, ex, gt); end end
module tb_top;
  import dram_arb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, s0 = 1'b1, s1 = 1'b1, ale = 1'b0, go = 1'b0;
  logic bl = 1'b0, bh = 1'b0, a0 = 1'b0, ube_n = 1'b1, ilv = 1'b0, oe_n = 1'b0;
  logic rq_n, row_n, frc_n, rdy_n, wr_n, wlo_n, whi_n, pnd_n, syn_n, d1_n, d2_n, sb, oeo_n;
  logic wst = 1'b0, wlo = 1'b0, whi = 1'b0, pnd = 1'b0, sbs = 1'b0, refs = 1'b0, rows = 1'b0;
  logic ref_rdy = 1'b0;
  logic [2:0] tab [4] = '{3'h4, 3'h5, 3'h6, 3'h0};
  int failures = 0, checks_done = 0, lat = 0, run = 0, last_run = 0, gap = 0, last_gap = 0;
  always #20 clk = ~clk;
  dram_access_refresh_arbiter uut (
    .core_clk_in(clk), .nrst_in(rst_n), .chip_select_n_in(cs_n),
    .cpu_state_bit_zero_in(s0), .cpu_state_bit_one_in(s1), .addr_latch_en_in(ale),
    .bank_select_low_in(bl), .bank_select_high_in(bh), .byte_lane_select_in(a0),
    .upper_byte_enable_n_in(ube_n), .refresh_request_n_in(rq_n), .interleave_en_in(ilv),
    .output_enable_n_in(oe_n), .row_strobe_request_n_out(row_n), .force_refresh_cmd_n_out(frc_n),
    .wait_control_n_out(rdy_n), .write_strobe_n_out(wr_n), .low_byte_write_strobe_n_out(wlo_n),
    .high_byte_write_strobe_n_out(whi_n), .pending_cycle_flag_n_out(pnd_n),
    .refresh_request_synced_n_out(syn_n), .delay_stage_one_n_out(d1_n),
    .delay_stage_two_n_out(d2_n), .same_bank_recovery_out(sb), .outputs_oe_n_out(oeo_n));
  dram_ctrl_model far (.core_clk_in(clk), .go_in(go), .force_refresh_cmd_n_in(frc_n),
    .refresh_request_n_out(rq_n));
  // pre-edge values only: the outputs read here other than sb are registered and sb follows falling-edge inputs, so this reads settled state
  always @(posedge clk) begin
    wst |= (wr_n === 1'b0);
    wlo |= (wlo_n === 1'b0);
    whi |= (whi_n === 1'b0);
    pnd |= (pnd_n === 1'b0);
    sbs |= (sb === 1'b1);
    refs |= (frc_n === 1'b0);
    rows |= (row_n === 1'b0);
    if (row_n === 1'b0) begin
      run++;
      if (gap != 0) begin
        last_gap = gap;
      end
      gap = 0;
    end else begin
      gap++;
      if (run != 0) begin
        last_run = run;
      end
      run = 0;
    end
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_idle();
    `check("idle strobes", 10'h3ff, {row_n, frc_n, rdy_n, wr_n, wlo_n, whi_n, pnd_n, syn_n, d1_n, d2_n})
    `check("idle recovery", 1'b0, sb)
  endtask
  task automatic idle(input int n);
    @(negedge clk);
    cs_n = 1'b1;
    repeat (n) @(posedge clk);
  endtask
  // status held two edges past the latch strobe, as a host in its first state
  task automatic access(input logic wr, input bank_t bk, input logic lane, input logic ube, input logic rq);
    @(negedge clk);
    {wst, wlo, whi, pnd, sbs, refs, rows} = '0;
    cs_n = 1'b0; // latched select with status
    {s1, s0} = wr ? CODE_WRITE : CODE_READ;
    ale = 1'b1;
    {bh, bl} = bk; // a1 is the low bank bit
    a0 = lane;
    ube_n = ube;
    go = rq;
    // lat counts rising edges from the latch edge until ready is seen low
    lat = 0;
    while (rdy_n !== 1'b0 && lat < 60) begin
      @(negedge clk);
      lat++;
      if (lat == 1) begin
        ale = 1'b0;
        go = 1'b0;
      end
      if (lat == 3) begin
        {s1, s0} = 2'b11;
      end
    end
    ref_rdy = frc_n;
    `check("ready", 1'b0, rdy_n)
  endtask
  task automatic kick();
    @(negedge clk);
    {pnd, sbs, refs, rows} = '0;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask
  task automatic wait_force();
    for (int i = 0; i < 12 && frc_n !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    `check("refresh command", 1'b0, frc_n)
  endtask
  task automatic t_oe();
    @(negedge clk);
    oe_n = 1'b1;
    #1;
    `check("pads off", 1'b1, oeo_n)
    oe_n = 1'b0;
    #1;
    `check("pads on", 1'b0, oeo_n)
  endtask
  task automatic t_nostart();
    @(negedge clk);
    rows = 1'b0;
    {s1, s0} = CODE_WRITE;
    ale = 1'b1;
    @(negedge clk);
    ale = 1'b0;
    repeat (2) @(negedge clk);
    {s1, s0} = 2'b11;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    `check("no cycle", 1'b0, rows)
  endtask
  task automatic t_bytes();
    logic [2:0] c;
    for (int i = 0; i < 4; i++) begin
      c = tab[i];
      access(c[2], bank_t'(i), c[1], c[0], 1'b0);
      `check("no-wait ready", ACCESS_PERIODS - 1, lat)
      idle(4);
      `check("write strobe", c[2], wst)
      `check("low lane", c[2] & ~c[1], wlo)
      `check("high lane", c[2] & ~c[0], whi)
      `check("row length", ROW_STROBE_PERIODS, last_run)
    end
  endtask
  task automatic t_bank();
    @(negedge clk);
    ilv = 1'b1;
    access(1'b0, 2'b01, 1'b0, 1'b0, 1'b0);
    access(1'b0, 2'b10, 1'b0, 1'b0, 1'b0);
    `check("other bank", ACCESS_PERIODS - 1, lat)
    `check("no recovery", 1'b0, sbs)
    access(1'b0, 2'b10, 1'b0, 1'b0, 1'b0);
    `check("recovery", 1'b1, sbs)
    `check("same bank waits", 1'b1, lat > ACCESS_PERIODS - 1)
    `check("precharge gap", WAIT_PERIODS, last_gap)
    idle(4);
    `check("row after wait", ROW_STROBE_PERIODS, last_run)
    @(negedge clk);
    ilv = 1'b0;
    access(1'b0, 2'b10, 1'b0, 1'b0, 1'b0);
    access(1'b0, 2'b10, 1'b0, 1'b0, 1'b0);
    `check("recovery off", 1'b0, sbs)
    idle(4);
  endtask
  task automatic t_refresh();
    kick();
    @(posedge clk);
    #1;
    `check("sync lag", 1'b1, syn_n)
    wait_force();
    idle(10);
    `check("row in refresh", 1'b1, rows)
    `check("refresh row", ROW_STROBE_PERIODS, last_run)
  endtask
  task automatic t_late();
    access(1'b1, 2'b00, 1'b0, 1'b0, 1'b1);
    `check("refresh held off", 1'b0, refs)
    wait_force();
    idle(10);
  endtask
  task automatic t_busy();
    kick();
    wait_force();
    access(1'b0, 2'b11, 1'b0, 1'b0, 1'b0);
    `check("pending seen", 1'b1, pnd)
    `check("refresh done", 1'b1, ref_rdy)
    `check("waits added", 1'b1, lat > ACCESS_PERIODS - 1)
    idle(4);
  endtask
  // a few hundred cycles expected; generous margin
  initial begin
    #(2000 * 40);
    failures++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    chk_idle();
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_idle();
    t_oe();
    t_nostart();
    t_bytes();
    t_bank();
    t_refresh();
    t_late();
    t_busy();
    finish_test();
  end
endmodule

// file: verilog/bank_tracker.sv
// last-bank history, same-bank detect and byte write enables
// assumes bank and byte pins are stable from address latch to end of access
`timescale 1ns/1ps
module bank_tracker (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic load_in,
  input wire logic refresh_active_in,
  input wire logic row_active_in,
  input wire logic delay_one_in,
  input wire logic write_active_in,
  input wire dram_arb_pkg::bank_t bank_in,
  input wire logic byte_lane_select_in,
  input wire logic upper_byte_enable_n_in,
  output logic same_bank_out,
  output logic low_strobe_out,
  output logic high_strobe_out
);
  import dram_arb_pkg::*;

  typedef struct packed {
    logic [BANK_COUNT-1:0] last_bank;
    logic low;
    logic high;
  } track_state_t;

  track_state_t st;
  track_state_t next_st;
  logic [BANK_COUNT-1:0] hit;
  logic strobe_ok;

  // one flag per bank, loaded as each access starts
  for (genvar i = 0; i < BANK_COUNT; i++) begin : g_bank
    assign hit[i] = st.last_bank[i] && (bank_in == BANK_W'(i)); // [R20]
  end

  // recovery window is row strobe idle with first delay still running
  // [R7] interleave disabled holds the indication inactive
  assign same_bank_out = enable_in && (|hit) && !refresh_active_in
    && !row_active_in && delay_one_in; // [R20]

  assign strobe_ok = !refresh_active_in && row_active_in
    && delay_one_in && write_active_in;

  always_comb begin
    next_st = st;
    if (load_in) begin
      for (int b = 0; b < BANK_COUNT; b++) begin
        next_st.last_bank[b] = (bank_in == BANK_W'(b));
      end
    end
    next_st.low = strobe_ok && !byte_lane_select_in; // [R19]
    next_st.high = strobe_ok && !upper_byte_enable_n_in; // [R19]
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0; // [R27]
    end else begin
      st <= next_st;
    end
  end

  assign low_strobe_out = st.low;
  assign high_strobe_out = st.high;
endmodule

// file: verilog/dram_access_refresh_arbiter.sv
// host access and forced refresh arbiter in front of a dram controller
// assumes core_clk_in is the inverted double-rate host clock and that
// chip select, status and address latch are synchronous to it
`timescale 1ns/1ps
module dram_access_refresh_arbiter (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic chip_select_n_in,
  input wire logic cpu_state_bit_zero_in,
  input wire logic cpu_state_bit_one_in,
  input wire logic addr_latch_en_in,
  input wire logic bank_select_low_in,
  input wire logic bank_select_high_in,
  input wire logic byte_lane_select_in,
  input wire logic upper_byte_enable_n_in,
  input wire logic refresh_request_n_in,
  input wire logic interleave_en_in,
  input wire logic output_enable_n_in,
  output logic row_strobe_request_n_out,
  output logic force_refresh_cmd_n_out,
  output logic wait_control_n_out,
  output logic write_strobe_n_out,
  output logic low_byte_write_strobe_n_out,
  output logic high_byte_write_strobe_n_out,
  output logic pending_cycle_flag_n_out,
  output logic refresh_request_synced_n_out,
  output logic delay_stage_one_n_out,
  output logic delay_stage_two_n_out,
  output logic same_bank_recovery_out,
  output logic outputs_oe_n_out
);
  import dram_arb_pkg::*;

  // all flags held active high inside
  typedef struct packed {
    logic row;
    logic refresh;
    logic delay_one;
    logic delay_two;
    logic pending;
    logic write;
    logic ready;
  } arb_state_t;

  arb_state_t st;
  arb_state_t next_st;

  logic req_level;
  logic refresh_req;
  logic cs;
  logic ale;
  logic [1:0] code;
  logic rd_code;
  logic wr_code;
  logic acc_code;
  logic same_bank;
  logic row_start;
  logic low_strobe;
  logic high_strobe;
  bank_t bank;

  // the request pin is asynchronous; two flops before arbitration
  level_sync #(
    .RESET_LEVEL(PIN_IDLE)
  ) u_req_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .level_in(refresh_request_n_in),
    .level_out(req_level)
  );

  assign refresh_req = !req_level; // [R14]

  assign cs = !chip_select_n_in; // [R22]
  assign ale = addr_latch_en_in;
  assign code = {cpu_state_bit_one_in, cpu_state_bit_zero_in};
  assign rd_code = (code == CODE_READ);
  assign wr_code = (code == CODE_WRITE);
  assign acc_code = cs && (rd_code || wr_code); // [R23]
  assign bank = {bank_select_high_in, bank_select_low_in}; // [R1]
  assign row_start = next_st.row && !st.row && !st.refresh && !next_st.refresh;

  bank_tracker u_tracker (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .enable_in(interleave_en_in),
    .load_in(row_start),
    .refresh_active_in(st.refresh),
    .row_active_in(st.row),
    .delay_one_in(st.delay_one),
    .write_active_in(st.write),
    .bank_in(bank),
    .byte_lane_select_in(byte_lane_select_in),
    .upper_byte_enable_n_in(upper_byte_enable_n_in),
    .same_bank_out(same_bank),
    .low_strobe_out(low_strobe),
    .high_strobe_out(high_strobe)
  );

  // every term reads only state sampled before the edge [R8]
  always_comb begin
    next_st = st;

    // pending access: asked for during refresh or precharge [R13]
    next_st.pending =
      (st.refresh && acc_code)
      || (st.pending && st.refresh)
      || (st.pending && !st.row)
      || (st.pending && !st.delay_one)
      || (acc_code && !st.row && !st.delay_one && st.delay_two); // [R25]

    // write strobe from the decoded status at address latch [R18]
    next_st.write =
      (wr_code && cs && ale)
      || (st.write && !st.delay_one)
      || (st.write && st.refresh)
      || (st.write && st.row); // [R9]

    // row strobe request for refreshes and accesses [R15]
    next_st.row =
      (st.refresh && st.delay_one && !ale) // [R26]
      || (st.refresh && st.delay_one && st.row)
      || (!st.refresh && acc_code && !same_bank && !refresh_req
          && !ale) // [R6] [R12]
      || (st.row && !st.refresh && !st.delay_two) // [R4]
      || (!st.refresh && st.pending && !st.delay_one
          && !st.delay_two && !ale); // [R2] [R25]

    // forced refresh only once no access is under way [R24]
    next_st.refresh =
      (refresh_req && !st.row && !st.delay_one && st.delay_two)
      || (refresh_req && !st.row && st.delay_one && st.delay_two)
      || (refresh_req && !st.row && !st.delay_one && !st.delay_two
          && !st.pending) // [R16]
      || (st.refresh && st.delay_one)
      || (st.refresh && st.delay_two)
      || (st.refresh && refresh_req); // [R26]

    // first delay stage paces row strobe width and precharge [R6]
    next_st.delay_one =
      (st.refresh && !st.delay_two && refresh_req)
      || (st.refresh && st.row && !st.delay_two && st.delay_one)
      || (st.refresh && st.row && st.delay_one && ale)
      || (!st.refresh && st.row); // [R4]

    // second delay stage holds precharge on a same-bank hit [R6]
    next_st.delay_two =
      (st.refresh && st.row)
      || (st.refresh && st.delay_two && ale)
      || (!st.refresh && st.row && st.delay_one)
      || (!st.refresh && st.delay_one && st.delay_two && same_bank
          && !st.row && !refresh_req); // [R2]

    // ready ends the access; absent while refresh or precharge holds off
    next_st.ready = cs && st.row && !st.delay_one && !st.refresh; // [R17] [R5]
  end

  // async reset loads constants only; active-low outputs except outputs_oe_n_out idle high, same-bank flag idles low [R27]
  always_ff @(posedge core_clk_in or negedge nrst_in) begin // [R11] [R3]
    if (!nrst_in) begin
      st <= '{row: INACTIVE, refresh: INACTIVE, delay_one: INACTIVE,
              delay_two: INACTIVE, pending: INACTIVE, write: INACTIVE,
              ready: INACTIVE};
    end else begin
      st <= next_st; // [R8]
    end
  end

  // pins other than same_bank_recovery_out are active low; the inversion is outside the flops
  assign row_strobe_request_n_out = !st.row;
  assign force_refresh_cmd_n_out = !st.refresh;
  assign wait_control_n_out = !st.ready; // [R10]
  assign write_strobe_n_out = !st.write;
  assign low_byte_write_strobe_n_out = !low_strobe;
  assign high_byte_write_strobe_n_out = !high_strobe;
  assign pending_cycle_flag_n_out = !st.pending;
  assign refresh_request_synced_n_out = req_level;
  assign delay_stage_one_n_out = !st.delay_one;
  assign delay_stage_two_n_out = !st.delay_two;
  assign same_bank_recovery_out = same_bank;
  // pad drivers follow the enable; no tristate inside the core
  assign outputs_oe_n_out = output_enable_n_in; // [R21]

  // checks

  a_bank_select_map: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    bank == {bank_select_high_in, bank_select_low_in}
  ) else $error("bank index not built from the two address bits"); // [R1]

  a_request_synced: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ##2 refresh_request_synced_n_out == $past(refresh_request_n_in, 2)
  ) else $error("refresh request not delayed by two flops"); // [R14]

  a_refresh_after_access: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    $rose(st.refresh) |-> !$past(st.row)
  ) else $error("refresh started over an active row strobe"); // [R24]

  a_refresh_holds_request: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (st.refresh && refresh_req) |=> st.refresh
  ) else $error("refresh dropped while request still active"); // [R16]

  a_same_bank_blocks: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (same_bank && !st.row && !st.refresh) |=> !st.row
  ) else $error("row strobe started during same-bank recovery"); // [R12]

  a_pending_kept: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (st.pending && st.refresh) |=> st.pending
  ) else $error("pending access lost during refresh"); // [R13]

  a_ready_in_access: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    st.ready |-> ($past(st.row) && !$past(st.refresh) && $past(cs))
  ) else $error("ready given outside a selected access"); // [R17]

  a_low_strobe_qual: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    $fell(low_byte_write_strobe_n_out) |->
      ($past(st.write) && !$past(byte_lane_select_in))
  ) else $error("low byte write without write or lane select"); // [R19]

  a_write_from_code: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    $rose(st.write) |-> ($past(wr_code) && $past(cs) && $past(ale))
  ) else $error("write strobe started without decoded write"); // [R18]

  a_no_interleave_quiet: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !interleave_en_in |-> !same_bank_recovery_out
  ) else $error("same-bank flag raised with interleave off"); // [R7]

  a_row_needs_ale_low: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ($rose(st.row) && !$past(st.refresh)) |-> !$past(ale)
  ) else $error("row strobe started while address latch open"); // [R6]

  a_ready_single: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    st.ready |=> !st.ready
  ) else $error("ready held for more than one period"); // [R10]
endmodule

// file: verilog/dram_arb_pkg.sv
// constants and types shared by the access / refresh arbiter and its helpers
// assumes one clock, the inverted double-rate host clock, and an active-low async reset
// Operation
// R1 - bank select comes from word address bits one and two
// R2 - same-bank back-to-back access waits for precharge with host wait states
// R3 - logic runs on the double-rate clock, four periods per host bus cycle
// R4 - row strobe request stays active three clock periods per access
// R5 - wait states are two periods; row strobe stays aligned to host cycle
// R6 - address latch strobe qualifies row strobe and both delay stages
// R7 - without interleaving the same-bank indication stays inactive
// R8 - registered outputs change on the rising clock edge from sampled state
// R9 - every write is a late write; data paths buffered outside
// R10 - zero-wait access takes four periods; wait states lengthen it
// R11 - clock input is the inverted double-rate system clock
// R12 - same-bank indication delays row strobe and inserts wait states
// R13 - pending flag set for access during refresh or precharge, held until started
// R14 - refresh request registered on the clock before arbitration
// R15 - row strobe request raised for every access and every refresh
// R16 - refresh started by raising the forced-refresh command
// R17 - ready output inserts waits on refresh or precharge contention
// R18 - write strobe starts from decoded write status, held through access
// R19 - low and high byte write enables qualified by lane select and upper enable
// R20 - four last-bank flags compared with current bank give same-bank indication
// R21 - outputs driven only while output enable input is active
// R22 - outside logic supplies latched chip select and two status lines
// R23 - memory cycle starts only with chip select and read or write code
// R24 - refresh requested during an access waits until the access completes
// R25 - access during refresh waits through refresh and precharge, then runs
// R26 - refresh is forced in mode zero with three-period row strobe
// R27 - reset deasserts outputs and clears pending, delay and bank flags
package dram_arb_pkg;
  localparam int HOST_PERIOD_PS = 62500;
  localparam int CORE_PERIOD_PS = 40000;
  localparam int ACCESS_PERIODS = 4;
  localparam int ROW_STROBE_PERIODS = 3;
  localparam int WAIT_PERIODS = 2;
  localparam int SYNC_STAGES = 2;
  localparam int BANK_COUNT = 4;
  localparam int BANK_W = 2;
  localparam logic INACTIVE = 1'b0;
  localparam logic PIN_IDLE = 1'b1;
  // status codes seen on the two host status pins {one, zero}
  localparam logic [1:0] CODE_READ = 2'b01;
  localparam logic [1:0] CODE_WRITE = 2'b10;
  typedef logic [BANK_W-1:0] bank_t;
endpackage

// file: verilog/level_sync.sv
// two-flop synchroniser for one level arriving from outside the clock domain
// assumes the level is slow compared with the clock
`timescale 1ns/1ps
module level_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic level_in,
  output logic level_out
);
  import dram_arb_pkg::*;

  typedef struct packed {
    logic first;
    logic second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.first = level_in;
    // first stage feeds only the second stage
    next_st.second = st.first;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '{first: RESET_LEVEL, second: RESET_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.second;
endmodule
